// >>> logic/link_capture.sv
// Link-clock capture of the first edges of each chip-select frame.
// Assumes the host stops the link clock while chip select is high.
`default_nettype none
module link_capture
(
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic hresetn,
    input wire logic [3:0] io_in,
    output logic [31:0] nib_q,
    output logic [3:0] cnt_q
);
    import qpi_reset_pkg::*;

    typedef struct packed {
        logic [31:0] nib;
        logic [3:0] cnt;
    } cap_t;

    cap_t s_q;
    cap_t s_d;
    logic first_q;

    // Marks the next edge as a frame's first; set by deselect itself
    always_ff @(posedge sclk or posedge cs_n)
    begin
        if (cs_n)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    // Record every IO nibble of the first eight edges, count to saturation
    always_comb
    begin
        s_d = s_q;
        if (first_q)
        begin
            s_d.nib = {28'h0000000, io_in};
            s_d.cnt = 4'h1;
        end
        else if (s_q.cnt != EDGES_SAT)
        begin
            if (s_q.cnt < EDGES_SINGLE)
                s_d.nib[4 * s_q.cnt +: 4] = io_in;
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    // Holds still after deselect, so the bus side may read it then
    always_ff @(posedge sclk or negedge hresetn)
    begin
        if (!hresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign nib_q = s_q.nib;
    assign cnt_q = s_q.cnt;
endmodule : link_capture
`default_nettype wire

// >>> logic/qpi_reset_ctrl.sv
// Quad-mode exit and two-step software reset decoder with an AHB-Lite
// register slave. Assumes the link clock idles between frames.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module qpi_reset_ctrl
#(
    parameter int RECOVERY_CYCLES = qpi_reset_pkg::RECOVERY_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic quad_mode,
    output logic reset_busy,
    output logic abort_op,
    output logic [3:0] str_dummy_clocks,
    output logic [3:0] dtr_dummy_clocks,
    output logic [6:0] wrap_length_bytes
);
    import qpi_reset_pkg::*;

    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic cs_prev;
        logic quad;
        logic armed;
        logic [BUSY_W-1:0] busy_cnt;
        logic abort;
        logic quad_enable_bit;
        logic write_enable_latch;
        logic suspend_flag;
        logic [2:0] wrap_setting_bits;
        logic [7:0] read_parameter_field;
        logic [7:0] vstatus;
        logic [7:0] last_op;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } state_t;

    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(RECOVERY_CYCLES);
    localparam logic [BUSY_W-1:0] BUSY_ONE = BUSY_W'(1);
    // Field positions of the enable bit and the read parameter decode
    localparam int F_QE = 0;
    localparam int F_DUMMY_LSB = 4;
    localparam int F_LEN_LSB = 0;

    state_t s_q;
    state_t s_d;
    logic [31:0] nib;
    logic [3:0] cnt;
    logic frame_end;
    logic [3:0] need;
    logic [7:0] opcode;
    logic op_full;
    logic op_long;
    logic busy;
    logic ahb_take;
    logic [31:0] rd_mux;

    link_capture u_link
    (
        .sclk(sclk),
        .cs_n(cs_n),
        .hresetn(hresetn),
        .io_in(io_in),
        .nib_q(nib),
        .cnt_q(cnt)
    );

    // Frame ends when the synchronised select rises; captured edges
    // are quiet by then because the link clock has stopped
    assign frame_end = s_q.cs_sync & ~s_q.cs_prev;
    assign need = s_q.quad ? EDGES_QUAD : EDGES_SINGLE;
    assign op_full = (cnt == need);
    assign op_long = (cnt > need);
    assign busy = (s_q.busy_cnt != '0);

    // Opcode bits: one per edge on IO0, or one nibble per edge in quad
    always_comb
    begin
        opcode = {nib[3:0], nib[7:4]};
        if (!s_q.quad)
        begin
            for (int k = 0; k < 8; k++)
            begin
                opcode[7 - k] = nib[4 * k];
            end
        end
    end

    // Register read multiplexer
    always_comb
    begin
        rd_mux = 32'h00000000;
        case (haddr[7:0])
            ADDR_CONFIG: rd_mux[F_QE] = s_q.quad_enable_bit;
            ADDR_VOLATILE:
            begin
                rd_mux[F_WEL] = s_q.write_enable_latch;
                rd_mux[F_SUS] = s_q.suspend_flag;
                rd_mux[F_WRAP_LSB +: 3] = s_q.wrap_setting_bits;
                rd_mux[F_PARAM_LSB +: 8] = s_q.read_parameter_field;
            end
            ADDR_VSTATUS: rd_mux[7:0] = s_q.vstatus;
            ADDR_STATE: rd_mux[15:0] = {s_q.last_op, 4'h0, s_q.abort,
                busy, s_q.armed, s_q.quad};
            default: rd_mux = 32'h00000000;
        endcase
    end

    assign ahb_take = hsel & hready & (htrans == HTRANS_NONSEQ);

    // Next-state: synchroniser, bus slave, opcode decoder, recovery timer
    always_comb
    begin
        s_d = s_q;
        s_d.cs_meta = cs_n;
        s_d.cs_sync = s_q.cs_meta;
        s_d.cs_prev = s_q.cs_sync;
        s_d.abort = 1'b0;
        if (busy)
            s_d.busy_cnt = s_q.busy_cnt - BUSY_ONE;
        // Bus address phase; read data is ready in the data phase
        s_d.wr_pend = ahb_take & hwrite;
        if (ahb_take)
        begin
            s_d.wr_addr = haddr[7:0];
            s_d.rdata = hwrite ? 32'h00000000 : rd_mux;
        end
        // Data-phase writes; settings are frozen during recovery
        if (s_q.wr_pend && !busy)
        begin
            case (s_q.wr_addr)
                ADDR_CONFIG: s_d.quad_enable_bit = hwdata[F_QE];
                ADDR_VOLATILE:
                begin
                    s_d.write_enable_latch = hwdata[F_WEL];
                    s_d.suspend_flag = hwdata[F_SUS];
                    s_d.wrap_setting_bits = hwdata[F_WRAP_LSB +: 3];
                    s_d.read_parameter_field = hwdata[F_PARAM_LSB +: 8];
                end
                ADDR_VSTATUS: s_d.vstatus = hwdata[7:0];
                default: s_d.vstatus = s_q.vstatus;
            endcase
        end
        // Truncated frames fall through untouched; busy ignores all
        if (frame_end && !busy && (op_full || op_long))
        begin
            s_d.armed = 1'b0;
            if (op_full)
            begin
                s_d.last_op = opcode;
                case (opcode)
                    OP_RESET_ENABLE: s_d.armed = 1'b1;
                    OP_RESET:
                    begin
                        if (s_q.armed)
                        begin
                            // Volatile settings back to power-on values; the quad enable bit is kept and last_op holds the reset opcode
                            s_d.quad = 1'b0;
                            s_d.abort = 1'b1;
                            s_d.write_enable_latch = 1'b0;
                            s_d.suspend_flag = 1'b0;
                            s_d.read_parameter_field = PARAM_DEFAULT;
                            s_d.wrap_setting_bits = WRAP_DEFAULT;
                            s_d.vstatus = VSTATUS_DEFAULT;
                            s_d.busy_cnt = BUSY_LOAD;
                        end
                    end
                    OP_EXIT_QUAD:
                    begin
                        // Only a mode flip; latches deliberately kept
                        if (s_q.quad)
                            s_d.quad = 1'b0;
                    end
                    OP_ENTER_QUAD:
                    begin
                        if (!s_q.quad && s_q.quad_enable_bit)
                        begin
                            s_d.quad = 1'b1;
                            s_d.write_enable_latch = 1'b0;
                            s_d.suspend_flag = 1'b0;
                            s_d.wrap_setting_bits = WRAP_DEFAULT;
                        end
                    end
                    default: s_d.last_op = opcode;
                endcase
            end
        end
    end

    // Single state register; select synchroniser resets to deselected
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
            s_q.cs_meta <= 1'b1;
            s_q.cs_sync <= 1'b1;
            s_q.cs_prev <= 1'b1;
            s_q.wrap_setting_bits <= WRAP_DEFAULT;
            s_q.read_parameter_field <= PARAM_DEFAULT;
            s_q.vstatus <= VSTATUS_DEFAULT;
        end
        else
            s_q <= s_d;
    end

    // Outputs; zero-wait slave, always OKAY
    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign quad_mode = s_q.quad;
    assign reset_busy = busy;
    assign abort_op = s_q.abort;
    // Dummy count and wrap length follow the read parameter field
    assign str_dummy_clocks = STR_DUMMY_BASE
        + {1'b0, s_q.read_parameter_field[F_DUMMY_LSB +: 2], 1'b0};
    assign dtr_dummy_clocks = DTR_DUMMY_BASE
        + {1'b0, s_q.read_parameter_field[F_DUMMY_LSB +: 2], 1'b0};
    assign wrap_length_bytes = WRAP_BASE
        << s_q.read_parameter_field[F_LEN_LSB +: 2];

    // Helper decode for checks
    logic chk_op;
    assign chk_op = frame_end & ~busy & op_full;

    property p_exit_quad;
        @(posedge hclk) disable iff (!hresetn)
        chk_op && s_q.quad && opcode == OP_EXIT_QUAD |=> !quad_mode;
    endproperty
    a_exit_quad: assert property (p_exit_quad)
        else $error("exit opcode did not leave quad mode");

    property p_exit_keeps;
        @(posedge hclk) disable iff (!hresetn)
        chk_op && s_q.quad && opcode == OP_EXIT_QUAD && !s_q.wr_pend
        |=> $stable(s_q.write_enable_latch) && $stable(s_q.suspend_flag)
            && $stable(s_q.wrap_setting_bits);
    endproperty
    a_exit_keeps: assert property (p_exit_keeps)
        else $error("exit from quad mode changed latched settings");

    property p_reset_clears;
        @(posedge hclk) disable iff (!hresetn)
        chk_op && s_q.armed && opcode == OP_RESET |=> abort_op
            && !s_q.write_enable_latch && !s_q.suspend_flag
            && s_q.read_parameter_field == 8'h00 && !quad_mode
            ##1 !abort_op;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset did not restore defaults");

    property p_disarm;
        @(posedge hclk) disable iff (!hresetn)
        frame_end && !busy && (op_long || (op_full
            && opcode != OP_RESET_ENABLE)) |=> !s_q.armed;
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("reset enable survived another command");

    property p_busy_len;
        @(posedge hclk) disable iff (!hresetn)
        $rose(reset_busy) |-> s_q.busy_cnt == BUSY_LOAD
            ##1 reset_busy [*8];
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("recovery interval wrong");

    property p_busy_ignore;
        @(posedge hclk) disable iff (!hresetn)
        reset_busy && frame_end |=> $stable(quad_mode)
            && $stable(s_q.armed);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("command acted on during recovery");

    property p_enter_gate;
        @(posedge hclk) disable iff (!hresetn)
        chk_op && !s_q.quad && opcode == OP_ENTER_QUAD
        |=> quad_mode == $past(s_q.quad_enable_bit);
    endproperty
    a_enter_gate: assert property (p_enter_gate)
        else $error("enter quad ignored the quad enable bit");

    property p_enter_clears;
        @(posedge hclk) disable iff (!hresetn)
        $rose(quad_mode) |-> !s_q.write_enable_latch && !s_q.suspend_flag
            && s_q.wrap_setting_bits == WRAP_DEFAULT;
    endproperty
    a_enter_clears: assert property (p_enter_clears)
        else $error("enter quad kept latched settings");

    property p_defaults;
        @(posedge hclk) disable iff (!hresetn)
        $fell(abort_op) |-> str_dummy_clocks == 4'h2
            && dtr_dummy_clocks == 4'h4 && wrap_length_bytes == 7'h08;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("read defaults wrong after reset");

    property p_truncated;
        @(posedge hclk) disable iff (!hresetn)
        frame_end && cnt < need |=> $stable(quad_mode)
            && $stable(s_q.armed) && !abort_op;
    endproperty
    a_truncated: assert property (p_truncated)
        else $error("truncated opcode acted upon");

    c_reset_quad: cover property (@(posedge hclk) disable iff (!hresetn)
        abort_op && $past(s_q.quad));
    c_reset_single: cover property (@(posedge hclk) disable iff (!hresetn)
        abort_op && !$past(s_q.quad));
    c_exit: cover property (@(posedge hclk) disable iff (!hresetn)
        $fell(quad_mode) && !abort_op);
endmodule : qpi_reset_ctrl
`default_nettype wire

// >>> logic/qpi_reset_pkg.sv
// Constants shared by the quad-mode exit and software reset logic.
// Assumes a 125 MHz bus clock and an 8-bit serial opcode alphabet.
`default_nettype none
package qpi_reset_pkg;
    // Opcodes seen on the serial link
    localparam logic [7:0] OP_EXIT_QUAD = 8'hff;
    localparam logic [7:0] OP_ENTER_QUAD = 8'h38;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET = 8'h99;
    // Edges per opcode in each command mode
    localparam logic [3:0] EDGES_SINGLE = 4'h8;
    localparam logic [3:0] EDGES_QUAD = 4'h2;
    localparam logic [3:0] EDGES_SAT = 4'h9;
    // Reset recovery, rounded up to whole bus cycles
    localparam int RECOVERY_NS = 28000;
    localparam int HCLK_PERIOD_NS = 8;
    localparam int RECOVERY_CYC =
        (RECOVERY_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;
    localparam int BUSY_W = 12;
    // Register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_VOLATILE = 8'h04;
    localparam logic [7:0] ADDR_VSTATUS = 8'h08;
    localparam logic [7:0] ADDR_STATE = 8'h0c;
    // Field positions in the volatile settings register
    localparam int F_WEL = 0;
    localparam int F_SUS = 1;
    localparam int F_WRAP_LSB = 8;
    localparam int F_PARAM_LSB = 16;
    // Power-on defaults
    localparam logic [2:0] WRAP_DEFAULT = 3'h0;
    localparam logic [7:0] PARAM_DEFAULT = 8'h00;
    localparam logic [7:0] VSTATUS_DEFAULT = 8'h00;
    // Dummy clock and wrap length decode bases
    localparam logic [3:0] STR_DUMMY_BASE = 4'h2;
    localparam logic [3:0] DTR_DUMMY_BASE = 4'h4;
    localparam logic [6:0] WRAP_BASE = 7'h08;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : qpi_reset_pkg
`default_nettype wire

// >>> verification/host_link_model.sv
// Behavioural host serial controller: chip select, clock and data.
// Assumes one frame at a time, started by the bench through frame().
`default_nettype none
module host_link_model
(
    output var logic sclk,
    output var logic cs_n,
    output var logic [3:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link: deselected, clock parked low
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io_in = 4'h5;
    end

    // One frame of a given edge count; clock still outside the frame
    task automatic frame(input logic [7:0] op, input bit quad,
        input int edges);
        logic [7:0] sh;
        sh = op;
        #3;
        cs_n = 1'b0;
        for (int i = 0; i < edges; i++)
        begin
            io_in = quad ? sh[7:4] : {io_in[3:1], sh[7]};
            sh = quad ? (sh << 4) : (sh << 1);
            #12 sclk = 1'b1;
            #24 sclk = 1'b0;
            #12;
        end
        cs_n = 1'b1;
        // Released data no longer shows the last value
        io_in = ~io_in;
        // Gap well above the deselect time and the decode latency
        #104;
    endtask : frame
endmodule : host_link_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the quad exit and software reset decoder.
// Assumes the host model above drives the link with its own timing.
`default_nettype none
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import qpi_reset_pkg::*;
    // Short recovery keeps the run brief; the idle wait bound derives from it
    localparam int REC = 200;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata;
    logic [31:0] rdv;
    logic hreadyout, hresp, quad_mode, reset_busy, abort_op;
    logic sclk, cs_n;
    logic [3:0] io_in, str_dummy_clocks, dtr_dummy_clocks;
    logic [6:0] wrap_length_bytes;
    int errors = 0;
    int compares = 0;
    int aborts = 0;
    int busy_run = 0;

    always #4 hclk = ~hclk;

    host_link_model host (.sclk(sclk), .cs_n(cs_n), .io_in(io_in));

    qpi_reset_ctrl #(.RECOVERY_CYCLES(REC)) dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk),
        .cs_n(cs_n), .io_in(io_in), .quad_mode(quad_mode),
        .reset_busy(reset_busy), .abort_op(abort_op),
        .str_dummy_clocks(str_dummy_clocks),
        .dtr_dummy_clocks(dtr_dummy_clocks),
        .wrap_length_bytes(wrap_length_bytes)
    );

    // Abort pulses and the length of the latest recovery run
    always @(posedge hclk)
    begin
        if (abort_op === 1'b1)
        begin
            aborts++;
            busy_run = 0;
        end
        if (reset_busy === 1'b1)
            busy_run++;
    end

    task automatic stop_test();
        if (errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    // Bounded wait for a ready edge; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64)
        begin
            errors++;
            stop_test();
        end
    endtask : wait_ready

    // One single AHB transfer; read data lands in rdv
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rdv = hrdata;
    endtask : ahb

    task automatic wait_idle();
        for (int n = 0; n < REC + 64 && reset_busy === 1'b1; n++)
            @(posedge hclk);
        #1;
        if (reset_busy !== 1'b0)
        begin
            errors++;
            stop_test();
        end
    endtask : wait_idle

    // Power-up state, register defaults and an unmapped place
    task automatic t_defaults();
        `CHK(quad_mode, 1'b0);
        `CHK({hreadyout, hresp}, 2'b10);
        `CHK({str_dummy_clocks, dtr_dummy_clocks}, 8'h24);
        `CHK(wrap_length_bytes, 7'h08);
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        for (int a = 0; a < 20; a += 4)
        begin
            ahb(1'b0, a[7:0], 32'h0);
            `CHK(rdv, 32'h0);
        end
    endtask : t_defaults

    // Entry needs the enable bit and clears write state
    task automatic t_enter();
        host.frame(OP_ENTER_QUAD, 1'b0, 8);
        `CHK(quad_mode, 1'b0);
        ahb(1'b1, ADDR_CONFIG, 32'h1);
        ahb(1'b1, ADDR_VOLATILE, 32'h0000_0503);
        host.frame(OP_ENTER_QUAD, 1'b0, 8);
        `CHK(quad_mode, 1'b1);
        ahb(1'b0, ADDR_VOLATILE, 32'h0);
        `CHK(rdv & 32'h0000_0703, 32'h0);
        host.frame(OP_ENTER_QUAD, 1'b1, 2);
        `CHK(quad_mode, 1'b1);
    endtask : t_enter

    // A cut-short opcode is ignored; exit keeps write state
    task automatic t_exit();
        ahb(1'b1, ADDR_VOLATILE, 32'h0000_0503);
        host.frame(OP_EXIT_QUAD, 1'b1, 1);
        `CHK(quad_mode, 1'b1);
        host.frame(OP_EXIT_QUAD, 1'b1, 2);
        `CHK(quad_mode, 1'b0);
        ahb(1'b0, ADDR_VOLATILE, 32'h0);
        `CHK(rdv, 32'h0000_0503);
        host.frame(OP_EXIT_QUAD, 1'b0, 8);
        `CHK(quad_mode, 1'b0);
        ahb(1'b0, ADDR_VOLATILE, 32'h0);
        `CHK(rdv, 32'h0000_0503);
    endtask : t_exit

    // Reset in quad mode; an arm attempt while recovering is lost
    task automatic t_reset_quad();
        int a0;
        host.frame(OP_ENTER_QUAD, 1'b0, 8);
        ahb(1'b1, ADDR_VOLATILE, 32'h0031_0503);
        ahb(1'b1, ADDR_VSTATUS, 32'h0000_00a5);
        `CHK({str_dummy_clocks, dtr_dummy_clocks}, 8'h8a);
        `CHK(wrap_length_bytes, 7'h10);
        ahb(1'b0, ADDR_STATE, 32'h0);
        `CHK(rdv[2], 1'b0);
        a0 = aborts;
        host.frame(OP_RESET_ENABLE, 1'b1, 2);
        host.frame(OP_RESET, 1'b1, 2);
        `CHK(aborts, a0 + 1);
        `CHK({quad_mode, reset_busy}, 2'b01);
        host.frame(OP_RESET_ENABLE, 1'b0, 8);
        wait_idle();
        `CHK(busy_run, REC);
        host.frame(OP_RESET, 1'b0, 8);
        `CHK(aborts, a0 + 1);
        `CHK({str_dummy_clocks, dtr_dummy_clocks}, 8'h24);
        `CHK(wrap_length_bytes, 7'h08);
        ahb(1'b0, ADDR_VOLATILE, 32'h0);
        `CHK(rdv, 32'h0);
        ahb(1'b0, ADDR_VSTATUS, 32'h0);
        `CHK(rdv, 32'h0);
    endtask : t_reset_quad

    // Other frames disarm, long ones too; a truncated one does not
    task automatic t_disarm();
        int a0;
        ahb(1'b1, ADDR_VSTATUS, 32'h0000_005a);
        a0 = aborts;
        host.frame(OP_RESET_ENABLE, 1'b0, 8);
        host.frame(8'h05, 1'b0, 8);
        host.frame(OP_RESET, 1'b0, 8);
        host.frame(OP_RESET_ENABLE, 1'b0, 8);
        host.frame(OP_RESET, 1'b0, 9);
        host.frame(OP_RESET, 1'b0, 8);
        `CHK(aborts, a0);
        ahb(1'b0, ADDR_VSTATUS, 32'h0);
        `CHK(rdv, 32'h0000_005a);
        host.frame(OP_RESET_ENABLE, 1'b0, 8);
        host.frame(OP_RESET, 1'b0, 3);
        host.frame(OP_RESET, 1'b0, 8);
        `CHK(aborts, a0 + 1);
        wait_idle();
        ahb(1'b0, ADDR_VSTATUS, 32'h0);
        `CHK(rdv, 32'h0);
    endtask : t_disarm

    // Main sequence; the link waits out the synchroniser flush
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        #1;
        t_defaults();
        t_enter();
        t_exit();
        t_reset_quad();
        t_disarm();
        stop_test();
    end
endmodule : testbench
`undef CHK
`default_nettype wire
